// File: hw/wake_ready_status.sv
`timescale 1ns/1ps

//
// Contract
// [R1] Written ones clear wake cause; reset zero.
// [R2] Bit0 PHY wake, bit1 LAN-type wakes.
// [R3] LPI wakes set EEE flag per sleep level.
// [R4] Several cause bits may be set together.
// [R5] Cause sets only if enabled for level.
// [R6] Global wake enables never gate cause recording.
// [R7] Resume clears bit1 when auto clear set.
// [R8] Oscillator disable default: EEPROM, OTP, else one.
// [R9] USB or lite reset reload oscillator default.
// [R10] Internal PHY: unconfigured keeps ready clear.
// [R11] External PHY: ready after image load.
// [R12] Internal PHY: ready after PHY operational.
// [R13] External PHY: configuring leaves ready set.
// [R14] Internal PHY reset during sleep level two.
// [R15] External PHY untouched by sleep level two.
// [R16] PHY reset trigger keeps ready clear.
// [R17] Trigger holds reset 4 ms, self clears.
// [R18] Sleep select two bits, resets to two.
// [R19] Written zero leaves cause bit unchanged.
//
module wake_ready_status (
   // Clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_n,
   input  wire logic                           i_usb_reset,
   input  wire logic                           i_lite_soft_reset,
   // Configuration
   input  wire logic                           i_external_phy,
   input  wire wake_ready_pkg::image_type      i_image,
   input  wire logic                           i_image_loaded,
   input  wire logic                           i_osc_dis_wr,
   input  wire logic                           i_osc_dis_wdata,
   input  wire logic                           i_sleep_sel_wr,
   input  wire logic [1:0]                     i_sleep_sel_wdata,
   input  wire logic                           i_resume_clears_wake_cause,
   input  wire logic                           i_lan_wake_enable,
   input  wire logic                           i_phy_interrupt_wake_enable,
   // Per level wake enables, indexed by sleep level
   input  wire wake_ready_pkg::wake_enable_type i_level_en [4],
   // Power state
   input  wire logic                           i_configured,
   input  wire logic                           i_suspended,
   input  wire logic                           i_resume_done,
   input  wire logic                           i_phy_operational,
   // Wake events
   input  wire wake_ready_pkg::wake_event_type i_events,
   // Software clears and PHY reset trigger
   input  wire logic                           i_wake_clr_wr,
   input  wire logic [1:0]                     i_wake_clr_data,
   input  wire logic                           i_eee_clr_wr,
   input  wire logic                           i_phy_reset_wr,
   // Status
   output logic [1:0]                          o_wake_cause_status,
   output logic                                o_eee_wake_flag,
   output logic                                o_oscillator_suspend_disable,
   output logic [1:0]                          o_sleep_level_select,
   output logic                                o_phy_reset_trigger,
   output logic                                o_phy_reset,
   output logic                                o_device_ready
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Chooses the image value for the oscillator suspend disable.
   function automatic logic image_osc(input wake_ready_pkg::image_type img);
      if (img.eeprom_present) begin
         image_osc = img.eeprom_osc_dis;
      end else if (img.otp_present) begin
         image_osc = img.otp_osc_dis;
      end else begin
         image_osc = wake_ready_pkg::OSC_DIS_FALLBACK;
      end
   endfunction : image_osc

   // Updates a sticky bit, a set winning over a clear.
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                           soft_rst;
   logic                           img_osc;
   logic                           timer_busy;
   logic                           int_phy_hold;
   logic                           trig_take;
   logic                           phy_set;
   logic                           lan_set;
   logic                           eee_set;
   logic                           suspend_l2;
   logic                           ready_nxt;
   wake_ready_pkg::wake_enable_type lvl_en;
   wake_ready_pkg::sleep_level_type lvl;
   wake_ready_pkg::power_state_type pstate_r;
   wake_ready_pkg::power_state_type pstate_nxt;

   assign soft_rst = i_usb_reset | i_lite_soft_reset;
   assign img_osc  = image_osc(i_image);
   assign lvl      = wake_ready_pkg::sleep_level_type'(o_sleep_level_select);
   assign lvl_en   = i_level_en[o_sleep_level_select];

   // ----------------------------------------------------------------
   // Wake cause recording
   // ----------------------------------------------------------------
   // Global wake enables are deliberately not used here.
   assign phy_set = i_events.phy_wake & lvl_en.phy_en;           // [R5] [R6] [R2]
   assign lan_set = i_events.lan_wake & lvl_en.lan_en;           // [R5] [R6] [R2]
   assign eee_set = (i_events.lpi_receive_wake &
                     (lvl == wake_ready_pkg::SLEEP_L0 || lvl == wake_ready_pkg::SLEEP_L3)) |
                    (i_events.lpi_transmit_wake & (lvl == wake_ready_pkg::SLEEP_L3)); // [R3]

   // Each cause bit is sticky; only a written one clears it, or a resume for bit1 when auto clear is set.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_wake_cause_status <= wake_ready_pkg::WAKE_CAUSE_RST;       // [R1]
      end else begin
         o_wake_cause_status[wake_ready_pkg::WAKE_PHY_BIT] <= sticky(
            o_wake_cause_status[wake_ready_pkg::WAKE_PHY_BIT], phy_set,
            i_wake_clr_wr & i_wake_clr_data[wake_ready_pkg::WAKE_PHY_BIT]); // [R1] [R4] [R19]
         o_wake_cause_status[wake_ready_pkg::WAKE_LAN_BIT] <= sticky(
            o_wake_cause_status[wake_ready_pkg::WAKE_LAN_BIT], lan_set,
            (i_wake_clr_wr & i_wake_clr_data[wake_ready_pkg::WAKE_LAN_BIT]) |
            (i_resume_done & i_resume_clears_wake_cause));           // [R1] [R7] [R19]
      end
   end

   // The EEE flag is independent of the cause field.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_eee_wake_flag <= 1'b0;
      end else begin
         o_eee_wake_flag <= sticky(o_eee_wake_flag, eee_set, i_eee_clr_wr); // [R3]
      end
   end

   // ----------------------------------------------------------------
   // Oscillator suspend disable
   // ----------------------------------------------------------------
   // Reloaded from the image on every soft reset and image load.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_oscillator_suspend_disable <= wake_ready_pkg::OSC_DIS_FALLBACK;
      end else if (soft_rst || i_image_loaded) begin
         o_oscillator_suspend_disable <= img_osc;                     // [R8] [R9]
      end else if (i_osc_dis_wr) begin
         o_oscillator_suspend_disable <= i_osc_dis_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Sleep level select
   // ----------------------------------------------------------------
   // Returns to level two whenever the device is unconfigured.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_sleep_level_select <= wake_ready_pkg::SLEEP_SEL_RST;       // [R18]
      end else if (soft_rst || !i_configured) begin
         o_sleep_level_select <= wake_ready_pkg::SLEEP_SEL_RST;       // [R18]
      end else if (i_sleep_sel_wr) begin
         o_sleep_level_select <= i_sleep_sel_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Power state tracking
   // ----------------------------------------------------------------
   always_comb begin
      pstate_nxt = pstate_r;
      case (pstate_r)
         wake_ready_pkg::PWR_UNCONF: begin
            if (i_configured) begin
               pstate_nxt = wake_ready_pkg::PWR_CONF;
            end
         end
         wake_ready_pkg::PWR_CONF: begin
            if (!i_configured) begin
               pstate_nxt = wake_ready_pkg::PWR_UNCONF;
            end else if (i_suspended) begin
               pstate_nxt = wake_ready_pkg::PWR_SUSPEND;
            end
         end
         wake_ready_pkg::PWR_SUSPEND: begin
            if (!i_configured) begin
               pstate_nxt = wake_ready_pkg::PWR_UNCONF;
            end else if (!i_suspended) begin
               pstate_nxt = wake_ready_pkg::PWR_CONF;
            end
         end
         default: begin
            pstate_nxt = wake_ready_pkg::PWR_UNCONF;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         pstate_r <= wake_ready_pkg::PWR_UNCONF;
      end else begin
         pstate_r <= pstate_nxt;
      end
   end

   // ----------------------------------------------------------------
   // PHY reset
   // ----------------------------------------------------------------
   assign trig_take = i_phy_reset_wr & ~o_phy_reset_trigger;          // [R17]

   phy_reset_timer #(
      .HOLD_CYCLES (wake_ready_pkg::PHY_RESET_TRIGGER_CYCLES)
   ) u_timer (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_start (trig_take),
      .o_busy  (timer_busy)
   );

   // Self clearing trigger bit follows the timer hold.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_phy_reset_trigger <= 1'b0;
      end else if (trig_take) begin
         o_phy_reset_trigger <= 1'b1;                                 // [R17]
      end else if (o_phy_reset_trigger && !timer_busy) begin
         o_phy_reset_trigger <= 1'b0;                                 // [R17]
      end
   end

   // Internal PHY sits in reset while unconfigured or suspended at level two.
   assign suspend_l2   = (pstate_r == wake_ready_pkg::PWR_SUSPEND) &&
                         (lvl == wake_ready_pkg::SLEEP_L2);
   assign int_phy_hold = ~i_external_phy &                            // [R10] [R14] [R15]
                         ((pstate_r == wake_ready_pkg::PWR_UNCONF) | suspend_l2);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_phy_reset <= 1'b1;
      end else begin
         o_phy_reset <= int_phy_hold | trig_take | o_phy_reset_trigger; // [R14] [R17]
      end
   end

   // ----------------------------------------------------------------
   // Device ready
   // ----------------------------------------------------------------
   always_comb begin
      if (trig_take || o_phy_reset_trigger || o_phy_reset) begin
         ready_nxt = 1'b0;                                            // [R16] [R10] [R14]
      end else if (i_external_phy) begin
         ready_nxt = o_device_ready | i_image_loaded;                 // [R11] [R13] [R15]
      end else begin
         ready_nxt = (pstate_r != wake_ready_pkg::PWR_UNCONF) & i_phy_operational; // [R12]
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         o_device_ready <= 1'b0;
      end else begin
         o_device_ready <= ready_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_trig_start;
      !o_phy_reset_trigger && i_phy_reset_wr;
   endsequence

   property p_clr_one;                                                // [R1]
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_wake_clr_wr && i_wake_clr_data[0] && !phy_set) |=> !o_wake_cause_status[0];
   endproperty
   a_clr_one: assert property (p_clr_one) else $error("cause bit not cleared"); // [R1]

   property p_zero_keeps;                                             // [R19]
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_wake_cause_status[0] && !(i_wake_clr_wr && i_wake_clr_data[0]))
         |=> o_wake_cause_status[0];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("cause bit lost"); // [R19]

   property p_set_enabled;                                            // [R5]
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_wake_cause_status[1]) |-> $past(lan_set);
   endproperty
   a_set_enabled: assert property (p_set_enabled) else $error("cause set without enable"); // [R5]

   property p_eee;                                                    // [R3]
      @(posedge i_clk) disable iff (!i_rst_n)
      eee_set |=> o_eee_wake_flag;
   endproperty
   a_eee: assert property (p_eee) else $error("eee flag missed"); // [R3]

   property p_resume;                                                 // [R7]
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_resume_done && i_resume_clears_wake_cause && !lan_set) |=> !o_wake_cause_status[1];
   endproperty
   a_resume: assert property (p_resume) else $error("resume did not clear"); // [R7]

   property p_osc;                                                    // [R9]
      @(posedge i_clk) disable iff (!i_rst_n)
      soft_rst |=> o_oscillator_suspend_disable == $past(img_osc);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator default wrong"); // [R9]

   property p_hold;                                                   // [R17]
      @(posedge i_clk) disable iff (!i_rst_n)
      s_trig_start |=> o_phy_reset_trigger [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("phy reset too short"); // [R17]

   property p_trig_ready;                                             // [R16]
      @(posedge i_clk) disable iff (!i_rst_n)
      o_phy_reset_trigger |=> !o_device_ready;
   endproperty
   a_trig_ready: assert property (p_trig_ready) else $error("ready during phy reset"); // [R16]

   property p_int_unconf;                                             // [R10]
      @(posedge i_clk) disable iff (!i_rst_n)
      (!i_external_phy && pstate_r == wake_ready_pkg::PWR_UNCONF) |=> !o_device_ready;
   endproperty
   a_int_unconf: assert property (p_int_unconf) else $error("ready while unconfigured"); // [R10]

   property p_sel_reset;                                              // [R18]
      @(posedge i_clk) disable iff (!i_rst_n)
      !i_configured |=> o_sleep_level_select == wake_ready_pkg::SLEEP_SEL_RST;
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("sleep select not reset"); // [R18]

   property p_reset_ready;                                            // [R14]
      @(posedge i_clk) disable iff (!i_rst_n)
      o_phy_reset |=> !o_device_ready;
   endproperty
   a_reset_ready: assert property (p_reset_ready) else $error("ready during phy hold"); // [R14]

   property p_ext_untouched;                                          // [R15]
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_external_phy && !trig_take && !o_phy_reset_trigger) |=> !o_phy_reset;
   endproperty
   a_ext_untouched: assert property (p_ext_untouched) else $error("external phy reset"); // [R15]

endmodule : wake_ready_status

// File: hw/wake_ready_pkg.sv
package wake_ready_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ            = 20000000;
   localparam int unsigned PHY_RESET_TRIGGER_MIN_MS    = 4;
   localparam int unsigned PHY_RESET_TRIGGER_CYCLES    = (CLK_HZ / 1000) * PHY_RESET_TRIGGER_MIN_MS;
   localparam int unsigned PHY_RESET_TRIGGER_CNT_W     = 20;

   // ----------------------------------------------------------------
   // Reset values and field layouts
   // ----------------------------------------------------------------
   localparam logic [1:0] WAKE_CAUSE_RST     = 2'h0;
   localparam int unsigned WAKE_PHY_BIT      = 0;
   localparam int unsigned WAKE_LAN_BIT      = 1;
   localparam logic       OSC_DIS_FALLBACK   = 1'h1;
   localparam logic [1:0] SLEEP_SEL_RST      = 2'h2;

   // Sleep level encodings.
   typedef enum logic [1:0] {
      SLEEP_L0 = 2'h0,
      SLEEP_L1 = 2'h1,
      SLEEP_L2 = 2'h2,
      SLEEP_L3 = 2'h3
   } sleep_level_type;

   // Power states of the device.
   typedef enum logic [1:0] {
      PWR_UNCONF  = 2'h0,
      PWR_CONF    = 2'h1,
      PWR_SUSPEND = 2'h2
   } power_state_type;

   // Wake events from the detectors.
   typedef struct packed {
      logic phy_wake;
      logic lan_wake;
      logic lpi_receive_wake;
      logic lpi_transmit_wake;
   } wake_event_type;

   // Per sleep level enables of the wake events.
   typedef struct packed {
      logic phy_en;
      logic lan_en;
   } wake_enable_type;

   // Configuration image source flags.
   typedef struct packed {
      logic eeprom_present;
      logic eeprom_osc_dis;
      logic otp_present;
      logic otp_osc_dis;
   } image_type;

endpackage : wake_ready_pkg

// File: hw/phy_reset_timer.sv
`timescale 1ns/1ps

// Holds the PHY reset for a programmable minimum number of cycles.
module phy_reset_timer #(
   parameter int unsigned HOLD_CYCLES = wake_ready_pkg::PHY_RESET_TRIGGER_CYCLES
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Control
   input  wire logic i_start,
   // Status
   output logic      o_busy
);

   localparam logic [wake_ready_pkg::PHY_RESET_TRIGGER_CNT_W-1:0] LAST =
      wake_ready_pkg::PHY_RESET_TRIGGER_CNT_W'(HOLD_CYCLES - 1);

   logic [wake_ready_pkg::PHY_RESET_TRIGGER_CNT_W-1:0] cnt_r;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Starts only when idle, so a start during a hold is ignored.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_busy <= 1'b0;
         cnt_r  <= '0;
      end else if (!o_busy) begin
         if (i_start) begin
            o_busy <= 1'b1;
            cnt_r  <= '0;
         end
      end else if (cnt_r == LAST) begin
         o_busy <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

endmodule : phy_reset_timer

// File: verif/tb_wake_ready_status.sv
`timescale 1ns/1ps

module tb_wake_ready_status;

   // ----------------------------------------------------------------
   // Table of ordinary wake cases
   // ----------------------------------------------------------------
   // Level, its enables, event pulse, global enables, expected cause and flag.
   typedef struct packed {
      logic [1:0] lvl;
      logic [1:0] en;
      logic [3:0] ev;
      logic       glob;
      logic [1:0] cause;
      logic       eee;
   } row_type;

   localparam int NROWS = 11;
   localparam row_type ROWS [NROWS] = '{
      '{2'h0, 2'h3, 4'h8, 1'h1, 2'h1, 1'h0}, '{2'h0, 2'h3, 4'h4, 1'h1, 2'h2, 1'h0},
      '{2'h1, 2'h0, 4'hC, 1'h1, 2'h0, 1'h0}, '{2'h3, 2'h3, 4'hC, 1'h0, 2'h3, 1'h0},
      '{2'h0, 2'h2, 4'h4, 1'h1, 2'h0, 1'h0}, '{2'h2, 2'h1, 4'h8, 1'h0, 2'h0, 1'h0},
      '{2'h0, 2'h3, 4'h2, 1'h1, 2'h0, 1'h1}, '{2'h3, 2'h3, 4'h1, 1'h1, 2'h0, 1'h1},
      '{2'h0, 2'h3, 4'h1, 1'h1, 2'h0, 1'h0}, '{2'h2, 2'h3, 4'h2, 1'h1, 2'h0, 1'h0},
      '{2'h3, 2'h3, 4'h2, 1'h1, 2'h0, 1'h1}};

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic                             clk, rst_n, usb_reset, lite_reset, ext_phy, img_loaded;
   logic                             osc_wr, osc_wdata, sleep_wr, res_clr, lan_en, phy_int_en;
   logic                             configured, suspended, resume_done, phy_op;
   logic                             wclr_wr, eee_clr, trig_wr;
   logic [1:0]                       sleep_wdata, wclr_data, cause;
   logic [1:0]                       sleep_sel;
   logic                             eee, osc, trig, phy_reset_trigger, ready;
   wake_ready_pkg::image_type        image;
   wake_ready_pkg::wake_event_type   events;
   wake_ready_pkg::wake_enable_type  level_en [4];
   int                               err_total;
   int                               comparisons;

   wake_ready_status dut_u (
      .i_clk(clk), .i_rst_n(rst_n), .i_usb_reset(usb_reset), .i_lite_soft_reset(lite_reset),
      .i_external_phy(ext_phy), .i_image(image), .i_image_loaded(img_loaded),
      .i_osc_dis_wr(osc_wr), .i_osc_dis_wdata(osc_wdata), .i_sleep_sel_wr(sleep_wr),
      .i_sleep_sel_wdata(sleep_wdata), .i_resume_clears_wake_cause(res_clr),
      .i_lan_wake_enable(lan_en), .i_phy_interrupt_wake_enable(phy_int_en),
      .i_level_en(level_en), .i_configured(configured), .i_suspended(suspended),
      .i_resume_done(resume_done), .i_phy_operational(phy_op), .i_events(events),
      .i_wake_clr_wr(wclr_wr), .i_wake_clr_data(wclr_data), .i_eee_clr_wr(eee_clr),
      .i_phy_reset_wr(trig_wr), .o_wake_cause_status(cause), .o_eee_wake_flag(eee),
      .o_oscillator_suspend_disable(osc), .o_sleep_level_select(sleep_sel),
      .o_phy_reset_trigger(trig), .o_phy_reset(phy_reset_trigger), .o_device_ready(ready));

   // ----------------------------------------------------------------
   // Clock and helpers
   // ----------------------------------------------------------------
   // Free running 20 MHz clock.
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   // Advances n cycles, one by default, and lands just after the edge, where inputs change.
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Pulses one strobe for a single cycle.
   task automatic pulse(ref logic s);
      s = 1'h1;
      step();
      s = 1'h0;
   endtask : pulse

   // Drives an event pulse for a single cycle.
   task automatic fire(input logic [3:0] ev);
      events = wake_ready_pkg::wake_event_type'(ev);
      step();
      events = '0;
   endtask : fire

   // Writes the clear strobe with the given ones.
   task automatic wclr(input logic [1:0] d);
      wclr_data = d;
      pulse(wclr_wr);
   endtask : wclr

   // Waits a bounded time for ready; the PHY reset must be released by then.
   task automatic wait_ready(input int bound);
      int n;
      n = 0;
      while (ready !== 1'h1 && n < bound) begin
         step();
         n++;
      end
      chk("ready_rise", 2'h1, {1'h0, ready});
      chk("phy_reset_at_ready", 2'h0, {1'h0, phy_reset_trigger});
   endtask : wait_ready

   // Prints the verdict and stops the run.
   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // Cuts a hang short well beyond the long PHY reset hold.
   initial begin
      repeat (95000) @(posedge clk);
      err_total++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int cnt;
      logic held;
      err_total = 0;
      comparisons = 0;
      {rst_n, usb_reset, lite_reset, ext_phy, img_loaded, osc_wr, osc_wdata} = '0;
      {sleep_wr, res_clr, lan_en, phy_int_en, suspended, resume_done, phy_op} = '0;
      {wclr_wr, eee_clr, trig_wr, sleep_wdata, wclr_data} = '0;
      {configured, image, events} = '0;
      for (int k = 0; k < 4; k++) level_en[k] = '0;
      step(3);
      rst_n = 1'h1;
      step();
      chk("cause_rst", 2'h0, cause);
      chk("sleep_rst", 2'h2, sleep_sel);
      chk("osc_rst", 2'h1, {1'h0, osc});
      chk("trig_rst", 2'h0, {1'h0, trig});
      configured = 1'h1;
      ext_phy = 1'h1;
      // Table rows: clear everything, pick the level, then one event pulse.
      for (int r = 0; r < NROWS; r++) begin
         for (int k = 0; k < 4; k++)
            level_en[k] = (k == ROWS[r].lvl) ? ROWS[r].en : ~ROWS[r].en;
         {lan_en, phy_int_en} = {2{ROWS[r].glob}};
         {wclr_wr, wclr_data, eee_clr, sleep_wr, sleep_wdata} = {1'h1, 2'h3, 2'h3, ROWS[r].lvl};
         step();
         {wclr_wr, eee_clr, sleep_wr} = '0;
         chk("sleep_sel", ROWS[r].lvl, sleep_sel);
         fire(ROWS[r].ev);
         chk("cause_row", ROWS[r].cause, cause);
         chk("eee_row", {1'h0, ROWS[r].eee}, {1'h0, eee});
      end
      // Written ones clear only their own bits.
      fire(4'hC);
      wclr(2'h1);
      chk("wclr_01", 2'h2, cause);
      wclr(2'h0);
      chk("wclr_00", 2'h2, cause);
      wclr(2'h2);
      chk("wclr_10", 2'h0, cause);
      // Resume clears the LAN cause only when the auto clear is on.
      fire(4'hC);
      pulse(resume_done);
      chk("resume_keep", 2'h3, cause);
      res_clr = 1'h1;
      pulse(resume_done);
      chk("resume_clear", 2'h1, cause);
      // Oscillator default precedence and reload on soft resets.
      configured = 1'h0;
      image = wake_ready_pkg::image_type'(4'h2);
      pulse(img_loaded);
      chk("osc_otp", 2'h0, {1'h0, osc});
      osc_wdata = 1'h1;
      pulse(osc_wr);
      pulse(lite_reset);
      chk("osc_lite", 2'h0, {1'h0, osc});
      chk("sleep_lite", 2'h2, sleep_sel);
      image = wake_ready_pkg::image_type'(4'hE);
      pulse(img_loaded);
      chk("osc_eep1", 2'h1, {1'h0, osc});
      image = wake_ready_pkg::image_type'(4'hB);
      pulse(img_loaded);
      chk("osc_eep0", 2'h0, {1'h0, osc});
      image = '0;
      pulse(img_loaded);
      chk("osc_none", 2'h1, {1'h0, osc});
      osc_wdata = 1'h0;
      pulse(osc_wr);
      pulse(usb_reset);
      chk("osc_usb", 2'h1, {1'h0, osc});
      // External PHY: ready after load, kept through configure and suspend.
      pulse(img_loaded);
      wait_ready(10);
      configured = 1'h1;
      step(5);
      chk("ext_conf_ready", 2'h1, {1'h0, ready});
      sleep_wdata = 2'h2;
      pulse(sleep_wr);
      held = phy_reset_trigger;
      suspended = 1'h1;
      step(5);
      chk("ext_l2_ready", 2'h1, {1'h0, ready});
      chk("ext_l2_phy", {1'h0, held}, {1'h0, phy_reset_trigger});
      suspended = 1'h0;
      pulse(resume_done);
      // Internal PHY: clear while unconfigured, ready once configured.
      {configured, ext_phy, phy_op} = 3'h1;
      pulse(lite_reset);
      pulse(img_loaded);
      for (int i = 0; i < 10; i++) begin
         step();
         chk("int_unconf_ready", 2'h0, {1'h0, ready});
      end
      configured = 1'h1;
      wait_ready(50);
      suspended = 1'h1;
      cnt = 0;
      while (phy_reset_trigger !== 1'h1 && cnt < 20) begin
         step();
         cnt++;
      end
      chk("int_l2_phy", 2'h1, {1'h0, phy_reset_trigger});
      suspended = 1'h0;
      pulse(resume_done);
      wait_ready(50);
      // Trigger: long hold, ready clear, second write ignored.
      pulse(trig_wr);
      chk("trig_set", 2'h1, {1'h0, trig});
      chk("trig_phy", 2'h1, {1'h0, phy_reset_trigger});
      cnt = 0;
      held = 1'h0;
      while (trig === 1'h1 && cnt < 90000) begin
         if (ready !== 1'h0) held = 1'h1;
         trig_wr = (cnt == 10);
         step();
         cnt++;
      end
      chk("trig_ready_low", 2'h0, {1'h0, held});
      chk("trig_hold_min", 2'h1, {1'h0, cnt >= wake_ready_pkg::PHY_RESET_TRIGGER_CYCLES});
      chk("trig_hold_max", 2'h1, {1'h0, cnt <= wake_ready_pkg::PHY_RESET_TRIGGER_CYCLES + 2});
      wait_ready(50);
      give_verdict();
   end

endmodule : tb_wake_ready_status
